// file: bss_bus_agent.sv
// far-side agent model on the secondary bus: tenure, grant and error pulses
`timescale 1ns/10ps
module bss_bus_agent (
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic       go,
  input  wire logic       drop,
  input  wire logic [2:0] ev,
  output logic            BUS_START,
  output logic            BUS_DONE,
  output logic            BUS_GNT,
  output logic            DATA_PHASE_END,
  output logic            PARITY_ERR,
  output logic            MASTER_ABORT,
  output logic            TARGET_ABORT
);
  logic [4:0] cnt_reg;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_reg <= 5'h00;
      {BUS_START, BUS_DONE, BUS_GNT, DATA_PHASE_END} <= 4'h0;
      {TARGET_ABORT, MASTER_ABORT, PARITY_ERR} <= 3'h0;
    end else begin
      cnt_reg <= go ? 5'h01 : cnt_reg + {4'h0, cnt_reg != 5'h00};
      BUS_START <= go;
      // grant withdrawn early so expiry must end the tenure
      BUS_GNT <= (cnt_reg != 5'h00) && !(drop && cnt_reg >= 5'h04);
      // late phase end: release only shows if the timer ran out first
      DATA_PHASE_END <= cnt_reg == 5'h14;
      BUS_DONE <= cnt_reg == 5'h18;
      {TARGET_ABORT, MASTER_ABORT, PARITY_ERR} <= ev;
    end
  end
endmodule : bss_bus_agent

// file: bss_pkg.sv
// types shared by the secondary-side bridge block
package bss_pkg;
  typedef enum logic [1:0] {
    BSS_IDLE    = 2'b00,
    BSS_OWN     = 2'b01,
    BSS_RELEASE = 2'b11
  } bss_tenure_t;
endpackage : bss_pkg

// file: bss_regs.svh
// register offsets, field positions and reset values for the secondary-side bridge block
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH
`define BSS_OFF_LAT_TIMER   8'h1b
`define BSS_OFF_IO_BASE     8'h1c
`define BSS_OFF_IO_LIMIT    8'h1d
`define BSS_OFF_STATUS_LO   8'h1e
`define BSS_OFF_STATUS_HI   8'h1f
`define BSS_LAT_RESET       8'h00
`define BSS_LAT_MASK        8'hf8
`define BSS_IO_BASE_RESET   8'hf0
`define BSS_IO_LIMIT_RESET  8'h00
`define BSS_IO_MASK         8'hf0
`define BSS_STATUS_RESET    16'h02a0
`define BSS_STATUS_FIXED    16'h02a0
`define BSS_BIT_PERR        15
`define BSS_BIT_MABORT      13
`define BSS_BIT_TABORT      12
`define BSS_IO_LOW_ZERO     12'h000
`define BSS_IO_LOW_ONES     12'hfff
`endif

// file: bss_secondary_io_status.sv
// secondary-side latency timer, i/o window decode and secondary status for the virtual bridge
//
// Contract
// (RQ1) latency field bits 7:3 r/w, zero disables
// (RQ2) latency timer bounds bridge tenure on secondary
// (RQ3) forward i/o when base <= address <= limit
// (RQ4) i/o base bits 7:4 hold A[15:12]
// (RQ5) base decode takes A[11:0] as zero
// (RQ6) limit bits 7:4, decode low bits as FFFh
// (RQ7) set bit 15 on secondary parity error
// (RQ8) software writes one to clear error flags
// (RQ9) set bit 13 on unexpected master abort
// (RQ10) set bit 12 on received target abort
// (RQ11) bit 14 always reads zero
// (RQ12) bit 11 zero, never signal target abort
// (RQ13) bits 10:9 always read 01b
// (RQ14) bit 8 always reads zero
// (RQ15) bit 7 reads one, accept back-to-back
// (RQ16) bit 5 reads one, 66 MHz capable
// (RQ17) reserved bits zero, zero writes no effect
// (RQ18) on expiry without grant, finish and release
`timescale 1ns/10ps
`include "bss_regs.svh"
module bss_secondary_io_status (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_WDATA,
  output logic      [7:0]  CFG_RDATA,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_REQ,
  output logic             IO_FORWARD,
  input  wire logic        BUS_START,
  input  wire logic        BUS_DONE,
  input  wire logic        BUS_GNT,
  input  wire logic        DATA_PHASE_END,
  output logic             BUS_OWNED,
  output logic             BUS_RELEASE,
  input  wire logic        PARITY_ERR,
  input  wire logic        MASTER_ABORT,
  input  wire logic        TARGET_ABORT,
  output logic             TARGET_ABORT_SIGNAL,
  output logic             BACK_TO_BACK_OK
);
  // configuration accesses come from logic on CLOCK, so no synchronisers are used

  logic [4:0]  tenure_count_value_reg;
  logic [3:0]  io_base_field_reg;
  logic [3:0]  io_limit_field_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [7:0]  tenure_ctr_reg;
  logic [7:0]  tenure_ctr_next;
  logic        forward_reg;
  bss_pkg::bss_tenure_t state_reg;
  bss_pkg::bss_tenure_t state_next;

  wire sel_lat = (CFG_ADDR == `BSS_OFF_LAT_TIMER);
  wire sel_base = (CFG_ADDR == `BSS_OFF_IO_BASE);
  wire sel_limit = (CFG_ADDR == `BSS_OFF_IO_LIMIT);
  wire sel_sts_lo = (CFG_ADDR == `BSS_OFF_STATUS_LO);
  wire sel_sts_hi = (CFG_ADDR == `BSS_OFF_STATUS_HI);
  wire sel_any = sel_lat | sel_base | sel_limit | sel_sts_lo | sel_sts_hi;

  wire wr_lat = CFG_WR & sel_lat;
  wire wr_base = CFG_WR & sel_base;
  wire wr_limit = CFG_WR & sel_limit;
  wire wr_sts_hi = CFG_WR & sel_sts_hi;

  // status flags; clears come only from a one in the written bit
  logic parity_error_seen;
  logic master_abort_received;
  logic target_abort_received;

  bss_w1c_flag u_perr (
    .clk         (CLOCK),
    .rst_n       (RESETN),
    .set_pulse   (PARITY_ERR),                                      // [RQ7]
    .clear_write (wr_sts_hi & CFG_WDATA[`BSS_BIT_PERR - 8]),          // [RQ8] [RQ17]
    .flag        (parity_error_seen)
  );

  bss_w1c_flag u_mabort (
    .clk         (CLOCK),
    .rst_n       (RESETN),
    .set_pulse   (MASTER_ABORT),                                    // [RQ9]
    .clear_write (wr_sts_hi & CFG_WDATA[`BSS_BIT_MABORT - 8]),        // [RQ8]
    .flag        (master_abort_received)
  );

  bss_w1c_flag u_tabort (
    .clk         (CLOCK),
    .rst_n       (RESETN),
    .set_pulse   (TARGET_ABORT),                                    // [RQ10]
    .clear_write (wr_sts_hi & CFG_WDATA[`BSS_BIT_TABORT - 8]),        // [RQ8]
    .flag        (target_abort_received)
  );

  // hardwired bits come from the fixed pattern: 14,11,8 zero, 10:9 01b, 7 and 5 one
  wire [15:0] status_word = `BSS_STATUS_FIXED                        // [RQ11] [RQ12] [RQ13] [RQ14] [RQ15] [RQ16]
                          | {parity_error_seen, 1'b0, master_abort_received, target_abort_received, 12'h000};

  wire [7:0] lat_word = {tenure_count_value_reg, 3'b000};            // [RQ17]
  wire [7:0] base_word = {io_base_field_reg, 4'h0};                  // [RQ4] [RQ17]
  wire [7:0] limit_word = {io_limit_field_reg, 4'h0};                // [RQ6] [RQ17]

  assign rdata_next = sel_lat    ? lat_word :
                      sel_base   ? base_word :
                      sel_limit  ? limit_word :
                      sel_sts_lo ? status_word[7:0] :
                      sel_sts_hi ? status_word[15:8] : 8'h00;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tenure_count_value_reg <= 5'(`BSS_LAT_RESET >> 3);
      io_base_field_reg      <= 4'(`BSS_IO_BASE_RESET >> 4);
      io_limit_field_reg     <= 4'(`BSS_IO_LIMIT_RESET >> 4);
    end else begin
      if (wr_lat) begin
        tenure_count_value_reg <= CFG_WDATA[7:3];                    // [RQ1]
      end
      if (wr_base) begin
        io_base_field_reg <= CFG_WDATA[7:4];                         // [RQ4]
      end
      if (wr_limit) begin
        io_limit_field_reg <= CFG_WDATA[7:4];                        // [RQ6]
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= 8'h00;
    end else if (CFG_RD) begin
      rdata_reg <= rdata_next;
    end
  end
  assign CFG_RDATA = rdata_reg;

  // i/o window: 4 KB granules, base low bits zero, limit low bits all ones
  wire [15:0] io_lo = {io_base_field_reg, `BSS_IO_LOW_ZERO};         // [RQ5]
  wire [15:0] io_hi = {io_limit_field_reg, `BSS_IO_LOW_ONES};        // [RQ6]
  wire        io_hit = (IO_ADDR >= io_lo) && (IO_ADDR <= io_hi);     // [RQ3]

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      forward_reg <= 1'b0;
    end else begin
      forward_reg <= IO_REQ & io_hit;                                // [RQ3]
    end
  end
  assign IO_FORWARD = forward_reg;

  // tenure timer: counts clocks from bus start; zero field means no limit
  wire timer_on = (tenure_count_value_reg != 5'h00);                 // [RQ1]
  wire expired = timer_on && (tenure_ctr_reg >= lat_word);           // [RQ2]

  always_comb begin
    state_next      = state_reg;
    tenure_ctr_next = tenure_ctr_reg;
    case (state_reg)
      bss_pkg::BSS_IDLE: begin
        tenure_ctr_next = 8'h00;
        if (BUS_START) begin
          state_next = bss_pkg::BSS_OWN;
        end
      end
      bss_pkg::BSS_OWN: begin
        if (!expired) begin
          tenure_ctr_next = tenure_ctr_reg + 8'h01;
        end
        if (BUS_DONE) begin
          state_next = bss_pkg::BSS_IDLE;
        end else if (expired && !BUS_GNT) begin
          state_next = bss_pkg::BSS_RELEASE;                         // [RQ18]
        end
      end
      bss_pkg::BSS_RELEASE: begin
        // the current data phase is allowed to finish before letting go
        if (DATA_PHASE_END || BUS_DONE) begin
          state_next = bss_pkg::BSS_IDLE;                            // [RQ18]
        end
      end
      default: begin
        state_next = bss_pkg::BSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg      <= bss_pkg::BSS_IDLE;
      tenure_ctr_reg <= 8'h00;
    end else begin
      state_reg      <= state_next;
      tenure_ctr_reg <= tenure_ctr_next;
    end
  end

  assign BUS_OWNED           = (state_reg != bss_pkg::BSS_IDLE);
  assign BUS_RELEASE         = (state_reg == bss_pkg::BSS_RELEASE) & (DATA_PHASE_END | BUS_DONE); // [RQ18]
  assign TARGET_ABORT_SIGNAL = 1'b0;                                 // [RQ12]
  assign BACK_TO_BACK_OK     = 1'b1;                                 // [RQ15]

  // checks
  a_perr_sets: assert property (@(posedge CLOCK) disable iff (!RESETN)   // [RQ7]
    PARITY_ERR |=> parity_error_seen) else $error("parity flag not set");

  a_mabort_sets: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ9]
    MASTER_ABORT |=> master_abort_received) else $error("master abort flag not set");

  a_tabort_sets: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ10]
    TARGET_ABORT |=> target_abort_received) else $error("target abort flag not set");

  a_zero_write_keeps: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ17]
    (wr_sts_hi && !CFG_WDATA[7] && parity_error_seen) |=> parity_error_seen)
    else $error("zero write cleared flag");

  a_clear_on_one: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ8]
    (wr_sts_hi && CFG_WDATA[5] && !MASTER_ABORT) |=> !master_abort_received)
    else $error("write one did not clear");

  a_fixed_status: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ13]
    (CFG_RD && sel_sts_hi) |=> ({CFG_RDATA[6], CFG_RDATA[3:0]} == 5'h02))
    else $error("fixed high status bits wrong");

  a_fixed_low: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ16]
    (CFG_RD && sel_sts_lo) |=> (CFG_RDATA == 8'ha0)) else $error("fixed low status bits wrong");

  a_base_read: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ4]
    (wr_base ##1 !CFG_WR ##1 (CFG_RD && sel_base && !CFG_WR))
    |=> (CFG_RDATA == {$past(CFG_WDATA, 3) & `BSS_IO_MASK}))
    else $error("io base readback wrong");

  a_io_forward: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ3]
    (IO_REQ && IO_ADDR[15:12] >= io_base_field_reg && IO_ADDR[15:12] <= io_limit_field_reg)
    |=> IO_FORWARD) else $error("window access not forwarded");

  sequence s_expire_no_gnt;
    (state_reg == bss_pkg::BSS_OWN) && expired && !BUS_GNT && !BUS_DONE;
  endsequence
  a_release_path: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ18]
    s_expire_no_gnt |=> (state_reg == bss_pkg::BSS_RELEASE)) else $error("no release on expiry");

  a_no_limit_off: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ1]
    (!timer_on && state_reg == bss_pkg::BSS_OWN && !BUS_DONE) |=> (state_reg == bss_pkg::BSS_OWN))
    else $error("disabled timer cut tenure");

  // write checks look at the fields, so a broken read mux cannot hide a lost write
  a_lat_written: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ1]
    wr_lat |=> (lat_word == ($past(CFG_WDATA) & `BSS_LAT_MASK)))
    else $error("latency field write lost");

  a_base_written: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ4]
    wr_base |=> (base_word == ($past(CFG_WDATA) & `BSS_IO_MASK)))
    else $error("io base write lost");

  a_limit_written: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ6]
    wr_limit |=> (limit_word == ($past(CFG_WDATA) & `BSS_IO_MASK)))
    else $error("io limit write lost");

  a_lat_reserved: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ17]
    (CFG_RD && sel_lat) |=> (CFG_RDATA[2:0] == 3'b000))
    else $error("latency reserved bits not zero");

  a_window_reserved: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ17]
    (CFG_RD && (sel_base || sel_limit)) |=> (CFG_RDATA[3:0] == 4'h0))
    else $error("window reserved bits not zero");

  a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ17]
    (CFG_RD && !sel_any) |=> (CFG_RDATA == 8'h00))
    else $error("unmapped offset read not zero");

  a_lat_keeps: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ1]
    !wr_lat |=> $stable(lat_word))
    else $error("latency field changed without write");

  a_window_keeps: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ3]
    (!wr_base && !wr_limit) |=> ($stable(io_lo) && $stable(io_hi)))
    else $error("window changed without write");

  a_io_outside: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ3]
    (IO_REQ && (IO_ADDR[15:12] < io_base_field_reg || IO_ADDR[15:12] > io_limit_field_reg)) |=> !IO_FORWARD)
    else $error("access outside window forwarded");

  a_io_idle: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ3]
    !IO_REQ |=> !IO_FORWARD)
    else $error("forward without request");

  // a clear racing a new event keeps the flag, so only clean clears are checked here
  a_perr_clears: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ8]
    (wr_sts_hi && CFG_WDATA[7] && !PARITY_ERR) |=> !parity_error_seen)
    else $error("parity flag not cleared");

  a_tabort_clears: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ8]
    (wr_sts_hi && CFG_WDATA[4] && !TARGET_ABORT) |=> !target_abort_received)
    else $error("target abort flag not cleared");

  a_perr_quiet: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ7]
    (!PARITY_ERR && !parity_error_seen) |=> !parity_error_seen)
    else $error("parity flag set without event");

  a_mabort_quiet: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ9]
    (!MASTER_ABORT && !master_abort_received) |=> !master_abort_received)
    else $error("master abort flag set without event");

  a_tabort_quiet: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ10]
    (!TARGET_ABORT && !target_abort_received) |=> !target_abort_received)
    else $error("target abort flag set without event");

  sequence s_tenure_start;
    (state_reg == bss_pkg::BSS_IDLE) && BUS_START;
  endsequence
  sequence s_phase_done;
    (state_reg == bss_pkg::BSS_RELEASE) && (DATA_PHASE_END || BUS_DONE);
  endsequence
  a_start_owns: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    s_tenure_start |=> BUS_OWNED)
    else $error("bus start did not take ownership");

  a_idle_not_owned: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    ((state_reg == bss_pkg::BSS_IDLE) && !BUS_START) |=> !BUS_OWNED)
    else $error("ownership without bus start");

  a_done_ends: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    ((state_reg == bss_pkg::BSS_OWN) && BUS_DONE) |=> !BUS_OWNED)
    else $error("tenure kept after done");

  a_grant_keeps: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    ((state_reg == bss_pkg::BSS_OWN) && expired && BUS_GNT && !BUS_DONE) |=> (state_reg == bss_pkg::BSS_OWN))
    else $error("tenure cut while grant held");

  a_count_steps: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    ((state_reg == bss_pkg::BSS_OWN) && !expired) |=> (tenure_ctr_reg == $past(tenure_ctr_reg) + 8'h01))
    else $error("tenure count did not advance");

  a_count_frozen: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ2]
    ((state_reg == bss_pkg::BSS_OWN) && expired) |=> (tenure_ctr_reg == $past(tenure_ctr_reg)))
    else $error("tenure count moved after expiry");

  a_release_waits: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ18]
    ((state_reg == bss_pkg::BSS_RELEASE) && !DATA_PHASE_END && !BUS_DONE) |=> (state_reg == bss_pkg::BSS_RELEASE))
    else $error("bus let go before data phase end");

  a_release_ends: assert property (@(posedge CLOCK) disable iff (!RESETN) // [RQ18]
    s_phase_done |=> !BUS_OWNED)
    else $error("bus held after data phase end");
endmodule : bss_secondary_io_status

// file: bss_w1c_flag.sv
// one sticky error flag, set by hardware, cleared by writing one
`timescale 1ns/10ps
module bss_w1c_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_pulse,
  input  wire logic clear_write,
  output logic      flag
);
  logic flag_reg;
  logic flag_next;

  // set wins over a clear in the same cycle so no event is lost
  assign flag_next = set_pulse | (flag_reg & ~clear_write);
  assign flag      = flag_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule : bss_w1c_flag

// file: test_bss_secondary_io_status.sv
// self-checking bench for the secondary-side bridge block
`timescale 1ns/10ps
module test_bss_secondary_io_status;
  logic        CLOCK = 1'b0, RESETN = 1'b0, CFG_WR = 1'b0, CFG_RD = 1'b0, IO_REQ = 1'b0;
  logic [7:0]  CFG_ADDR = 8'h00, CFG_WDATA = 8'h00, CFG_RDATA;
  logic [15:0] IO_ADDR = 16'h0000;
  logic        IO_FORWARD, BUS_START, BUS_DONE, BUS_GNT, DATA_PHASE_END, BUS_OWNED, BUS_RELEASE;
  logic        PARITY_ERR, MASTER_ABORT, TARGET_ABORT, TARGET_ABORT_SIGNAL, BACK_TO_BACK_OK;
  logic        go = 1'b0, drop = 1'b0, rd_seen, io_seen;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  b, l;
  logic [7:0]  q8[$];
  logic        q1[$];
  logic [15:0] tbl[6] = '{16'h2fff, 16'h3000, 16'h4abc, 16'h5fff, 16'h6000, 16'h0000};
  logic [7:0]  hb[3] = '{8'h82, 8'h22, 8'h12};
  int          n_errors = 0, num_checks = 0, n_rel = 0;
  integer      seed = 32'h87d1b5e8;
  always #4 CLOCK = ~CLOCK;
  bss_secondary_io_status u_dut (.CLOCK(CLOCK), .RESETN(RESETN), .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .IO_ADDR(IO_ADDR), .IO_REQ(IO_REQ),
    .IO_FORWARD(IO_FORWARD), .BUS_START(BUS_START), .BUS_DONE(BUS_DONE), .BUS_GNT(BUS_GNT),
    .DATA_PHASE_END(DATA_PHASE_END), .BUS_OWNED(BUS_OWNED), .BUS_RELEASE(BUS_RELEASE),
    .PARITY_ERR(PARITY_ERR), .MASTER_ABORT(MASTER_ABORT), .TARGET_ABORT(TARGET_ABORT),
    .TARGET_ABORT_SIGNAL(TARGET_ABORT_SIGNAL), .BACK_TO_BACK_OK(BACK_TO_BACK_OK));
  bss_bus_agent u_agent (.CLOCK(CLOCK), .RESETN(RESETN), .go(go), .drop(drop), .ev(ev),
    .BUS_START(BUS_START), .BUS_DONE(BUS_DONE), .BUS_GNT(BUS_GNT), .DATA_PHASE_END(DATA_PHASE_END),
    .PARITY_ERR(PARITY_ERR), .MASTER_ABORT(MASTER_ABORT), .TARGET_ABORT(TARGET_ABORT));
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8
  task automatic cmp1(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask : cmp1
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge CLOCK);
    CFG_WR <= 1'b1;
    CFG_ADDR <= ad;
    CFG_WDATA <= d;
    @(posedge CLOCK);
    CFG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge CLOCK);
    CFG_RD <= 1'b1;
    CFG_ADDR <= ad;
    q8.push_back(e);
    @(posedge CLOCK);
    CFG_RD <= 1'b0;
  endtask : rd
  // leaves the request up so calls run back to back
  task automatic io(input logic [15:0] ad);
    @(posedge CLOCK);
    IO_REQ <= 1'b1;
    IO_ADDR <= ad;
    q1.push_back(ad >= {b, 12'h000} && ad <= {l, 12'hfff});
  endtask : io
  task automatic tenure(input logic [4:0] f, input logic dr, input logic [7:0] e);
    wr(8'h1b, {f, 3'h7});
    n_rel = 0;
    @(posedge CLOCK);
    go <= 1'b1;
    drop <= dr;
    @(posedge CLOCK);
    go <= 1'b0;
    repeat (3) @(posedge CLOCK);
    cmp1("bus_owned", 1'b1, BUS_OWNED);
    repeat (30) @(posedge CLOCK);
    cmp1("bus_owned", 1'b0, BUS_OWNED);
    cmp8("releases", e, n_rel[7:0]);
  endtask : tenure
  task automatic results;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // reads and i/o answers come one cycle after the request edge
  always @(posedge CLOCK) begin
    if (rd_seen === 1'b1) cmp8("cfg_rdata", q8.pop_front(), CFG_RDATA);
    if (io_seen === 1'b1) cmp1("io_forward", q1.pop_front(), IO_FORWARD);
    if (BUS_RELEASE === 1'b1) n_rel++;
    rd_seen <= CFG_RD & RESETN;
    io_seen <= IO_REQ & RESETN;
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd(8'h1b, 8'h00);
    rd(8'h1c, 8'hf0);
    rd(8'h1d, 8'h00);
    rd(8'h1e, 8'ha0);
    rd(8'h1f, 8'h02);
    cmp1("target_abort_signal", 1'b0, TARGET_ABORT_SIGNAL);
    cmp1("back_to_back", 1'b1, BACK_TO_BACK_OK);
    wr(8'h1b, 8'hff);
    wr(8'h1d, 8'h3f);
    wr(8'h1e, 8'hff);
    wr(8'h20, 8'hff);
    rd(8'h1b, 8'hf8);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'hf0);
    rd(8'h1d, 8'h30);
    rd(8'h1e, 8'ha0);
    rd(8'h20, 8'h00);
    b = 4'h3;
    l = 4'h5;
    wr(8'h1c, 8'h30);
    wr(8'h1d, 8'h5f);
    foreach (tbl[i]) io(tbl[i]);
    // window changes only with the request down, so decode never sees a half-written window
    for (int r = 0; r < 4; r++) begin
      @(posedge CLOCK);
      IO_REQ <= 1'b0;
      b = 4'($random(seed));
      l = 4'($random(seed));
      wr(8'h1c, {b, 4'h0});
      wr(8'h1d, {l, 4'h0});
      repeat (12) io(16'($random(seed)));
    end
    @(posedge CLOCK);
    IO_REQ <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(posedge CLOCK);
      ev <= 3'h1 << k;
      @(posedge CLOCK);
      ev <= 3'h0;
      repeat (2) @(posedge CLOCK);
      rd(8'h1f, hb[k]);
      wr(8'h1f, 8'h00);
      rd(8'h1f, hb[k]);
      wr(8'h1f, 8'hff);
      rd(8'h1f, 8'h02);
    end
    tenure(5'h01, 1'b1, 8'h01);
    tenure(5'h01, 1'b0, 8'h00);
    tenure(5'h00, 1'b1, 8'h00);
    tenure(5'h1f, 1'b1, 8'h00);
    @(posedge CLOCK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd(8'h1b, 8'h00);
    rd(8'h1c, 8'hf0);
    repeat (3) @(posedge CLOCK);
    results();
  end
endmodule : test_bss_secondary_io_status
